/* rtl/pci_command_control.sv */
`timescale 1ns/100ps
`default_nettype none
`include "cmd_ctl_consts.svh"

module pci_command_control
  import cmd_ctl_pkg::*;
#(
  parameter step_cap_t STEP_CAP = STEP_OPTIONAL,
  parameter logic PALETTE_CAPABLE = 1'b0,
  parameter int AD_WIDTH = 32,
  parameter int CBE_WIDTH = 4
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  // Configuration access to the command and status words
  input wire logic cfg_wr_en,
  input wire logic [1:0] cfg_be,
  input wire logic [15:0] cfg_wdata,
  input wire logic parity_flag_clr,
  output logic [15:0] cfg_rdata,
  output logic detected_parity_flag,
  // Parity checking and PERR#
  input wire logic par_err_det,
  output logic perr_n_o,
  output logic perr_n_oe,
  // Parity generation
  input wire logic [AD_WIDTH-1:0] ad_drv,
  input wire logic [CBE_WIDTH-1:0] cbe_drv,
  input wire logic drv_en,
  output logic par_o,
  output logic par_oe,
  // Palette snooping
  input wire logic palette_wr_hit,
  output logic palette_claim,
  output logic palette_snoop_take,
  // Master request path
  input wire logic mst_req_in,
  input wire logic mst_is_write,
  input wire logic mst_full_line,
  output logic mst_req_o,
  output logic [3:0] mst_cmd_o,
  // Target decode results
  input wire logic special_cycle_seen,
  output logic special_cycle_take,
  input wire logic mem_hit,
  output logic mem_claim,
  input wire logic io_hit,
  output logic io_claim,
  output logic stepping_ctl
);

  ////////////////////////////////////////////////////////////////
  // Command register

  logic [15:0] cmd_d;
  logic [15:0] cmd_q;
  logic [15:0] wr_val;
  logic [15:0] cmd_reset;
  logic pflag_d;
  logic pflag_q;

  function automatic logic [15:0] merge_bytes(
    input logic [15:0] old_val,
    input logic [15:0] new_val,
    input logic [1:0] be
  );
    logic [15:0] res;
    res = old_val;
    if (be[0]) begin
      res[7:0] = new_val[7:0];
    end
    if (be[1]) begin
      res[15:8] = new_val[15:8];
    end
    return res;
  endfunction : merge_bytes

  // Forces the bits that the hardware fixes, whatever software wrote
  function automatic logic [15:0] fix_bits(input logic [15:0] val);
    logic [15:0] res;
    res = val & `CMD_RW_MASK;
    unique case (STEP_CAP)
      STEP_NEVER: res[`CMD_BIT_STEP] = 1'b0;
      STEP_ALWAYS: res[`CMD_BIT_STEP] = 1'b1;
      STEP_OPTIONAL: res[`CMD_BIT_STEP] = val[`CMD_BIT_STEP];
      default: res[`CMD_BIT_STEP] = 1'b0;
    endcase
    if (!PALETTE_CAPABLE) begin
      res[`CMD_BIT_PALETTE] = 1'b0;
    end
    // Special cycles are never monitored by this function, bit stays clear
    res[`CMD_BIT_SPECIAL] = 1'b0;
    return res;
  endfunction : fix_bits

  always_comb begin
    cmd_reset = `CMD_RESET_VAL;
    if (STEP_CAP != STEP_NEVER) begin
      cmd_reset[`CMD_BIT_STEP] = 1'b1;
    end
    wr_val = merge_bytes(cmd_q, cfg_wdata, cfg_be);
    cmd_d = cmd_q;
    if (cfg_wr_en) begin
      cmd_d = fix_bits(wr_val);
    end
    // Set wins over a clear in the same cycle
    pflag_d = pflag_q;
    if (parity_flag_clr) begin
      pflag_d = 1'b0;
    end
    if (par_err_det) begin
      pflag_d = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cmd_q <= cmd_reset;
      pflag_q <= 1'b0;
    end else begin
      cmd_q <= cmd_d;
      pflag_q <= pflag_d;
    end
  end

  logic resp_perr;
  logic en_palette;
  logic en_mwi;
  logic en_special;
  logic en_master;
  logic en_mem;
  logic en_io;
  logic all_off;

  always_comb begin
    resp_perr = cmd_q[`CMD_BIT_PERR_RESP];
    en_palette = cmd_q[`CMD_BIT_PALETTE];
    en_mwi = cmd_q[`CMD_BIT_MWI];
    en_special = cmd_q[`CMD_BIT_SPECIAL];
    en_master = cmd_q[`CMD_BIT_MASTER];
    en_mem = cmd_q[`CMD_BIT_MEM];
    en_io = cmd_q[`CMD_BIT_IO];
    // Logically off the bus except for configuration cycles
    all_off = (cmd_q == 16'h0000);
  end

  ////////////////////////////////////////////////////////////////
  // PERR# driver: one low clock per error clock, then one high clock before release

  perr_state_t perr_st_q;
  perr_state_t perr_st_d;
  logic perr_o_d;
  logic perr_oe_d;
  logic perr_o_q;
  logic perr_oe_q;

  always_comb begin
    perr_st_d = perr_st_q;
    perr_o_d = 1'b1;
    perr_oe_d = 1'b0;
    unique case (perr_st_q)
      PERR_IDLE: begin
        if (par_err_det && resp_perr) begin
          perr_st_d = PERR_ASSERT;
          perr_o_d = 1'b0;
          perr_oe_d = 1'b1;
        end
      end
      PERR_ASSERT: begin
        // Back-to-back errors keep the line low
        if (par_err_det && resp_perr) begin
          perr_o_d = 1'b0;
        end else begin
          perr_st_d = PERR_RELEASE;
        end
        perr_oe_d = 1'b1;
      end
      PERR_RELEASE: begin
        perr_st_d = PERR_IDLE;
        if (par_err_det && resp_perr) begin
          perr_st_d = PERR_ASSERT;
          perr_o_d = 1'b0;
          perr_oe_d = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      perr_st_q <= PERR_IDLE;
      perr_o_q <= 1'b1;
      perr_oe_q <= 1'b0;
    end else begin
      perr_st_q <= perr_st_d;
      perr_o_q <= perr_o_d;
      perr_oe_q <= perr_oe_d;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Target side claims

  logic pal_claim_d;
  logic pal_take_d;
  logic spc_take_d;
  logic mem_claim_d;
  logic io_claim_d;
  logic pal_claim_q;
  logic pal_take_q;
  logic spc_take_q;
  logic mem_claim_q;
  logic io_claim_q;

  always_comb begin
    // Snooping only copies the data; the real palette owner answers
    pal_claim_d = palette_wr_hit && !en_palette && en_io && !all_off;
    pal_take_d = palette_wr_hit && en_palette && !all_off;
    spc_take_d = special_cycle_seen && en_special && !all_off;
    mem_claim_d = mem_hit && en_mem && !all_off;
    io_claim_d = io_hit && en_io && !all_off;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pal_claim_q <= 1'b0;
      pal_take_q <= 1'b0;
      spc_take_q <= 1'b0;
      mem_claim_q <= 1'b0;
      io_claim_q <= 1'b0;
    end else begin
      pal_claim_q <= pal_claim_d;
      pal_take_q <= pal_take_d;
      spc_take_q <= spc_take_d;
      mem_claim_q <= mem_claim_d;
      io_claim_q <= io_claim_d;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Master side

  logic mst_req_d;
  logic mst_req_q;
  logic [3:0] mst_cmd_d;
  logic [3:0] mst_cmd_q;

  always_comb begin
    mst_req_d = mst_req_in && en_master;
    mst_cmd_d = mst_cmd_q;
    if (mst_req_in && mst_is_write) begin
      // Write-invalidate needs a whole line; a partial line falls back
      if (en_mwi && mst_full_line) begin
        mst_cmd_d = `BUS_CMD_MEM_WR_INV;
      end else begin
        mst_cmd_d = `BUS_CMD_MEM_WRITE;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      mst_req_q <= 1'b0;
      mst_cmd_q <= `BUS_CMD_MEM_WRITE;
    end else begin
      mst_req_q <= mst_req_d;
      mst_cmd_q <= mst_cmd_d;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Read-back

  logic [15:0] rdata_d;
  logic [15:0] rdata_q;

  always_comb begin
    rdata_d = cmd_q;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rdata_q <= `CMD_RESET_VAL;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  bus_parity_gen #(
    .AD_WIDTH(AD_WIDTH),
    .CBE_WIDTH(CBE_WIDTH)
  ) u_par (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .ad_drv(ad_drv),
    .cbe_drv(cbe_drv),
    .drv_en(drv_en),
    .par_o(par_o),
    .par_oe(par_oe)
  );

  assign cfg_rdata = rdata_q;
  assign detected_parity_flag = pflag_q;
  assign perr_n_o = perr_o_q;
  assign perr_n_oe = perr_oe_q;
  assign palette_claim = pal_claim_q;
  assign palette_snoop_take = pal_take_q;
  assign special_cycle_take = spc_take_q;
  assign mem_claim = mem_claim_q;
  assign io_claim = io_claim_q;
  assign mst_req_o = mst_req_q;
  assign mst_cmd_o = mst_cmd_q;
  assign stepping_ctl = cmd_q[`CMD_BIT_STEP];

endmodule : pci_command_control

`default_nettype wire

/* rtl/cmd_ctl_consts.svh */
`ifndef CMD_CTL_CONSTS_SVH
`define CMD_CTL_CONSTS_SVH

`define CMD_REG_OFFSET 8'h04
`define CMD_REG_WIDTH 16
`define CMD_BIT_STEP 7
`define CMD_BIT_PERR_RESP 6
`define CMD_BIT_PALETTE 5
`define CMD_BIT_MWI 4
`define CMD_BIT_SPECIAL 3
`define CMD_BIT_MASTER 2
`define CMD_BIT_MEM 1
`define CMD_BIT_IO 0
`define CMD_BIT_SERR 8
`define CMD_BIT_FBB 9
`define CMD_RESET_VAL 16'h0000
`define CMD_RW_MASK 16'h03ff
`define STAT_BIT_PARITY_FLAG 15
`define BUS_CMD_MEM_WRITE 4'h7
`define BUS_CMD_MEM_WR_INV 4'hf

`endif

/* rtl/cmd_ctl_pkg.sv */
package cmd_ctl_pkg;

  typedef enum logic [1:0] {
    STEP_NEVER,
    STEP_ALWAYS,
    STEP_OPTIONAL
  } step_cap_t;

  typedef enum {
    PERR_IDLE,
    PERR_ASSERT,
    PERR_RELEASE
  } perr_state_t;

endpackage : cmd_ctl_pkg

/* rtl/bus_parity_gen.sv */
`timescale 1ns/100ps
`default_nettype none

// Even parity over AD and C/BE, one clock behind the data it covers
module bus_parity_gen #(
  parameter int AD_WIDTH = 32,
  parameter int CBE_WIDTH = 4
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [AD_WIDTH-1:0] ad_drv,
  input wire logic [CBE_WIDTH-1:0] cbe_drv,
  input wire logic drv_en,
  output logic par_o,
  output logic par_oe
);

  logic par_d;
  logic par_q;
  logic oe_d;
  logic oe_q;

  // Generated whatever the parity response setting is
  always_comb begin
    par_d = ^{ad_drv, cbe_drv};
    oe_d = drv_en;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      par_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      par_q <= par_d;
      oe_q <= oe_d;
    end
  end

  assign par_o = par_q;
  assign par_oe = oe_q;

endmodule : bus_parity_gen

`default_nettype wire

/* verification/cmd_ctl_chk_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
`include "cmd_ctl_consts.svh"

module cmd_ctl_chk
  import cmd_ctl_pkg::*;
#(
  parameter int AD_WIDTH = 32,
  parameter int CBE_WIDTH = 4
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic cfg_wr_en,
  input wire logic [15:0] cfg_rdata,
  input wire logic detected_parity_flag,
  input wire logic par_err_det,
  input wire logic perr_n_o,
  input wire logic perr_n_oe,
  input wire logic [AD_WIDTH-1:0] ad_drv,
  input wire logic [CBE_WIDTH-1:0] cbe_drv,
  input wire logic drv_en,
  input wire logic par_o,
  input wire logic par_oe,
  input wire logic palette_claim,
  input wire logic palette_snoop_take,
  input wire logic mst_req_in,
  input wire logic mst_is_write,
  input wire logic mst_full_line,
  input wire logic mst_req_o,
  input wire logic [3:0] mst_cmd_o,
  input wire logic special_cycle_seen,
  input wire logic special_cycle_take,
  input wire logic mem_hit,
  input wire logic mem_claim,
  input wire logic io_claim
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic [1:0] up_q;
  logic wr_q;
  always_ff @(posedge ref_clk) begin
    up_q <= {up_q[0], rst_n};
    wr_q <= cfg_wr_en;
  end
  // Readback lags the command state, so only trust it with no write just taken
  wire logic st = up_q == 2'b11 && !wr_q;

  a_perr_drive_on: assert property (st && par_err_det && cfg_rdata[6] |=> !perr_n_o && perr_n_oe)
    else $error("error not flagged on the error pin");
  a_perr_stay_off: assert property (st && par_err_det && !cfg_rdata[6] |=> perr_n_o)
    else $error("error pin asserted while response off");
  a_parity_flag_sets: assert property (par_err_det |=> detected_parity_flag)
    else $error("detected parity flag not set");
  a_parity_even: assert property (drv_en |=> par_oe && par_o == ^{$past(ad_drv), $past(cbe_drv)})
    else $error("bus parity wrong");
  a_master_off: assert property (st && !cfg_rdata[2] |=> !mst_req_o)
    else $error("request issued with master disabled");
  a_mem_gate: assert property (st |=> mem_claim == $past(mem_hit && cfg_rdata[1]))
    else $error("memory claim not gated");
  a_zero_cmd_quiet: assert property (st && cfg_rdata == 16'h0000 |=>
    !(mem_claim || io_claim || palette_claim || mst_req_o))
    else $error("activity with all-zero command");
  a_mwi_select: assert property (st && mst_req_in && mst_is_write |=>
    mst_cmd_o == ($past(cfg_rdata[4] && mst_full_line) ? `BUS_CMD_MEM_WR_INV : `BUS_CMD_MEM_WRITE))
    else $error("write command choice wrong");
  a_special_ignored: assert property (special_cycle_seen |=> !special_cycle_take)
    else $error("special cycle taken");
  a_snoop_off: assert property (st && !cfg_rdata[5] |=> !palette_snoop_take)
    else $error("palette snoop without enable");

  c_perr: cover property (st && par_err_det && cfg_rdata[6]);
  c_mwi: cover property (mst_cmd_o == `BUS_CMD_MEM_WR_INV);
  c_mem: cover property (mem_claim);
endmodule : cmd_ctl_chk

bind pci_command_control cmd_ctl_chk #(.AD_WIDTH(AD_WIDTH), .CBE_WIDTH(CBE_WIDTH)) u_cmd_ctl_chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .cfg_wr_en(cfg_wr_en), .cfg_rdata(cfg_rdata),
  .detected_parity_flag(detected_parity_flag), .par_err_det(par_err_det), .perr_n_o(perr_n_o),
  .perr_n_oe(perr_n_oe), .ad_drv(ad_drv), .cbe_drv(cbe_drv), .drv_en(drv_en), .par_o(par_o),
  .par_oe(par_oe), .palette_claim(palette_claim), .palette_snoop_take(palette_snoop_take),
  .mst_req_in(mst_req_in), .mst_is_write(mst_is_write), .mst_full_line(mst_full_line),
  .mst_req_o(mst_req_o), .mst_cmd_o(mst_cmd_o), .special_cycle_seen(special_cycle_seen),
  .special_cycle_take(special_cycle_take), .mem_hit(mem_hit), .mem_claim(mem_claim), .io_claim(io_claim)
);
`default_nettype wire

/* verification/cfg_host_model.sv */
`timescale 1ns/100ps
`default_nettype none

module cfg_host_model (
  input wire logic ref_clk,
  output logic cfg_wr_en,
  output logic [1:0] cfg_be,
  output logic [15:0] cfg_wdata
);
  initial begin
    cfg_wr_en = 1'h0;
    cfg_be = 2'h0;
    cfg_wdata = 16'h0000;
  end
  // Released lanes carry the inverse, so stale data is never mistaken for valid
  task automatic wr(input logic [1:0] be, input logic [15:0] d);
    @(negedge ref_clk);
    cfg_wr_en = 1'h1;
    cfg_be = be;
    cfg_wdata = d;
    @(negedge ref_clk);
    cfg_wr_en = 1'h0;
    cfg_be = ~be;
    cfg_wdata = ~d;
  endtask : wr
endmodule : cfg_host_model
`default_nettype wire

/* verification/pci_command_control_tb.sv */
`timescale 1ns/100ps
`default_nettype none

module pci_command_control_tb;
  import cmd_ctl_pkg::*;
  logic ref_clk = 1'h0;
  logic rst_n = 1'h0;
  logic [9:0] stim = 10'h000;
  logic [31:0] ad_drv = 32'h0000_0000;
  logic [3:0] cbe_drv = 4'h0;
  int n_mismatch = 0;
  int n_tests = 0;
  wire logic cfg_wr_en, parity_flag_clr, par_err_det, drv_en, palette_wr_hit, mst_req_in, mst_is_write;
  wire logic mst_full_line, special_cycle_seen, mem_hit, io_hit;
  wire logic [1:0] cfg_be;
  wire logic [15:0] cfg_wdata;
  logic [15:0] cfg_rdata;
  logic [3:0] mst_cmd_o;
  logic detected_parity_flag, perr_n_o, perr_n_oe, par_o, par_oe, palette_claim, palette_snoop_take;
  logic mst_req_o, special_cycle_take, mem_claim, io_claim, stepping_ctl;
  assign {parity_flag_clr, par_err_det, drv_en, palette_wr_hit, mst_req_in, mst_is_write, mst_full_line,
    special_cycle_seen, mem_hit, io_hit} = stim;
  wire logic [7:0] outs = {perr_n_o, perr_n_oe, palette_claim, palette_snoop_take, mst_req_o,
    special_cycle_take, mem_claim, io_claim};

  cfg_host_model u_cfg_host_model (.ref_clk(ref_clk), .cfg_wr_en(cfg_wr_en), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata));
  pci_command_control u_pci_command_control (
    .ref_clk(ref_clk), .rst_n(rst_n), .cfg_wr_en(cfg_wr_en), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
    .parity_flag_clr(parity_flag_clr), .cfg_rdata(cfg_rdata), .detected_parity_flag(detected_parity_flag),
    .par_err_det(par_err_det), .perr_n_o(perr_n_o), .perr_n_oe(perr_n_oe), .ad_drv(ad_drv),
    .cbe_drv(cbe_drv), .drv_en(drv_en), .par_o(par_o), .par_oe(par_oe), .palette_wr_hit(palette_wr_hit),
    .palette_claim(palette_claim), .palette_snoop_take(palette_snoop_take), .mst_req_in(mst_req_in),
    .mst_is_write(mst_is_write), .mst_full_line(mst_full_line), .mst_req_o(mst_req_o),
    .mst_cmd_o(mst_cmd_o), .special_cycle_seen(special_cycle_seen), .special_cycle_take(special_cycle_take),
    .mem_hit(mem_hit), .mem_claim(mem_claim), .io_hit(io_hit), .io_claim(io_claim),
    .stepping_ctl(stepping_ctl)
  );

  initial begin
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic setreg(input logic [1:0] be, input logic [15:0] d, input logic [15:0] e);
    u_cfg_host_model.wr(be, d);
    @(negedge ref_clk);
    check(cfg_rdata, e);
  endtask : setreg

  // One-cycle stimulus; registered outputs are read at the following falling edge
  task automatic pul(input logic [9:0] s, input logic [7:0] e);
    @(negedge ref_clk);
    stim = s;
    @(negedge ref_clk);
    stim = 10'h000;
    check(16'(outs), 16'(e));
  endtask : pul

  task automatic final_report;
    if (n_mismatch == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : final_report

  initial begin
    repeat (8) @(negedge ref_clk);
    rst_n = 1'h1;
    repeat (3) @(negedge ref_clk);
    check(cfg_rdata, 16'h0080);
    check(16'(stepping_ctl), 16'h0001);
    setreg(2'h3, 16'h0000, 16'h0000);
    check(16'(stepping_ctl), 16'h0000);
    pul(10'h077, 8'h80);
    setreg(2'h3, 16'h03ff, 16'h03d7);
    setreg(2'h1, 16'h0000, 16'h0300);
    pul(10'h002, 8'h80);
    setreg(2'h2, 16'h0000, 16'h0000);
    setreg(2'h1, 16'h00ff, 16'h00d7);
    pul(10'h07f, 8'hab);
    check(16'(mst_cmd_o), 16'h000f);
    pul(10'h100, 8'h40);
    check(16'(detected_parity_flag), 16'h0001);
    pul(10'h200, 8'h80);
    check(16'(detected_parity_flag), 16'h0000);
    setreg(2'h1, 16'h0006, 16'h0006);
    pul(10'h13b, 8'h8a);
    check(16'(mst_cmd_o), 16'h0007);
    check(16'(detected_parity_flag), 16'h0001);
    for (int i = 0; i < 2; i++) begin
      ad_drv = 32'h1234_5678 + 32'(i);
      cbe_drv = 4'h3;
      pul(10'h080, 8'h80);
      check(16'({par_oe, par_o}), 16'({1'h1, ^{ad_drv, cbe_drv}}));
    end
    final_report();
  end

  // Hang guard: a stalled run is counted as a mismatch
  initial begin
    #5_000_000;
    n_mismatch++;
    final_report();
  end
endmodule : pci_command_control_tb
`default_nettype wire
